// [hdl/dtc_map.vh]
// Register map, field positions and reset values of the dual timer
`ifndef DTC_MAP_VH
`define DTC_MAP_VH

// ----------------------------------------------------------------
// Register word indices (bus address bits 5:2)
// ----------------------------------------------------------------
`define DTC_OFS_CTRL     4'h0
`define DTC_OFS_MODE     4'h1
`define DTC_OFS_LOW0     4'h2
`define DTC_OFS_HIGH0    4'h3
`define DTC_OFS_LOW1     4'h4
`define DTC_OFS_HIGH1    4'h5
`define DTC_ADDR_W       6

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define DTC_CTRL_OVF1    7
`define DTC_CTRL_RUN1    6
`define DTC_CTRL_OVF0    5
`define DTC_CTRL_RUN0    4

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define DTC_MODE_GATE_ENABLE_ONE   7
`define DTC_MODE_SRC1    6
`define DTC_MODE_M1_HI   5
`define DTC_MODE_M1_LO   4
`define DTC_MODE_GATE_ENABLE_ZERO   3
`define DTC_MODE_SRC0    2
`define DTC_MODE_M0_HI   1
`define DTC_MODE_M0_LO   0

// ----------------------------------------------------------------
// Mode field codes
// ----------------------------------------------------------------
`define DTC_M_PRESCALE   2'b00
`define DTC_M_WIDE       2'b01
`define DTC_M_RELOAD     2'b10
`define DTC_M_SPLIT      2'b11

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DTC_RST_CTRL     8'h00
`define DTC_RST_MODE     8'h00
`define DTC_RST_COUNT    8'h00

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define DTC_RESP_OKAY    2'b00
`define DTC_RESP_DECERR  2'b11

`endif

// [hdl/dtc_timer.v]
// Dual 16-bit timer/counter with an AXI4-Lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "dtc_map.vh"

// Function
// - Sixteen-bit counting chains low byte into high byte; high overflow sets flag.
// - Starting a timer leaves its count registers untouched.
// - Source zero increments once per peripheral cycle strobe.
// - Source one counts high-then-low samples of the count pin.
// - Input counts when running (timer one also while timer zero is split) and gate off or gate pin high.
// - Timer zero uses mode bits 3:0; timer one bits 7:4.
// - Gate enables sit at mode bits 7 and 3.
// - Mode 0 is 13-bit: five-bit prescaler feeding the high byte.
// - Mode 1 cascades both bytes into one 16-bit counter.
// - Rollover from all ones to zero sets the overflow flag.
// - Mode 2 low byte overflow sets flag and reloads from high byte.
// - High byte reload value may be written while running.
// - Servicing the interrupt clears that timer's overflow flag.
// - Split mode low byte of timer zero uses timer zero controls.
// - Split mode high byte counts cycles, runs on run one, sets flag one.
// - Timer one in mode 3 halts holding its count.
// - Mode field decodes 00 13-bit, 01 16-bit, 10 reload, 11 mode 3.
// - Control bits 7,6 are flag and run one; 5,4 flag and run zero.
// - Control register resets to zero.
// - Source select sits at mode bits 6 and 2.
module dtc_timer
(
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Write address channel
  input  wire [5:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // Write data channel
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // Write response channel
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // Read address channel
  input  wire [5:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // Read data channel
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Peripheral cycle strobe
  input  wire        periph_strobe,
  // External pins
  input  wire        count_pin_zero,
  input  wire        count_pin_one,
  input  wire        ext_gate_pin_zero,
  input  wire        ext_gate_pin_one,
  // Interrupt service acknowledge
  input  wire        irq_ack_zero,
  input  wire        irq_ack_one,
  // Overflow flags
  output wire        overflow_flag_zero,
  output wire        overflow_flag_one
);

  // ----------------------------------------------------------------
  // Counter step: returns {overflow, high, low}
  // ----------------------------------------------------------------
  function [16:0] dtc_step;
    input [1:0] mode;
    input [7:0] lo;
    input [7:0] hi;
    begin
      case (mode)
        `DTC_M_PRESCALE:
        begin
          if (lo[4:0] == 5'h1f)
            dtc_step = {(hi == 8'hff), hi + 8'h01, lo[7:5], 5'h00};
          else
            dtc_step = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
        end
        `DTC_M_WIDE:
        begin
          if ({hi, lo} == 16'hffff)
            dtc_step = {1'b1, 16'h0000};
          else
            dtc_step = {1'b0, {hi, lo} + 16'h0001};
        end
        `DTC_M_RELOAD:
        begin
          if (lo == 8'hff)
            dtc_step = {1'b1, hi, hi};
          else
            dtc_step = {1'b0, hi, lo + 8'h01};
        end
        default:
          dtc_step = {1'b0, hi, lo};
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [7:0]  run_control;
  reg         flag_zero;
  reg         flag_one;
  reg  [7:0]  timer_mode_register;
  reg  [7:0]  count_low_zero;
  reg  [7:0]  count_high_zero;
  reg  [7:0]  count_low_one;
  reg  [7:0]  count_high_one;
  wire [7:0]  timer_control_register;

  assign timer_control_register = {flag_one, run_control[`DTC_CTRL_RUN1],
                                   flag_zero, run_control[`DTC_CTRL_RUN0],
                                   4'h0};
  assign overflow_flag_zero = flag_zero;
  assign overflow_flag_one  = flag_one;

  wire run_control_zero = run_control[`DTC_CTRL_RUN0];
  wire run_control_one  = run_control[`DTC_CTRL_RUN1];

  // Field decode
  wire [1:0] mode_field_zero =
    timer_mode_register[`DTC_MODE_M0_HI:`DTC_MODE_M0_LO];
  wire [1:0] mode_field_one =
    timer_mode_register[`DTC_MODE_M1_HI:`DTC_MODE_M1_LO];
  wire gate_enable_zero   = timer_mode_register[`DTC_MODE_GATE_ENABLE_ZERO];
  wire gate_enable_one    = timer_mode_register[`DTC_MODE_GATE_ENABLE_ONE];
  wire source_select_zero = timer_mode_register[`DTC_MODE_SRC0];
  wire source_select_one  = timer_mode_register[`DTC_MODE_SRC1];

  // ----------------------------------------------------------------
  // Pin synchronisers and sampling
  // ----------------------------------------------------------------
  reg  [3:0] pin_meta;
  reg  [3:0] pin_sync;
  reg  [1:0] count_sample;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_meta     <= 4'h0;
      pin_sync     <= 4'h0;
      count_sample <= 2'h0;
    end
    else
    begin
      pin_meta <= {ext_gate_pin_one, ext_gate_pin_zero,
                   count_pin_one, count_pin_zero};
      pin_sync <= pin_meta;
      if (periph_strobe)
        count_sample <= pin_sync[1:0];
    end
  end

  // High sample then low sample, judged once per peripheral cycle
  wire [1:0] count_fall = {2{periph_strobe}} & count_sample
                          & ~pin_sync[1:0];

  wire src_zero = source_select_zero ? count_fall[0]
                                     : periph_strobe;
  wire src_one  = source_select_one  ? count_fall[1]
                                     : periph_strobe;

  wire split_mode = (mode_field_zero == `DTC_M_SPLIT);

  // Counted input gating
  wire tick_zero = src_zero & run_control_zero
                   & (~gate_enable_zero | pin_sync[2]);
  // Timer one run bit is lent to the split high byte
  wire tick_one  = src_one & (split_mode | run_control_one)
                   & (~gate_enable_one | pin_sync[3]);
  wire tick_high = periph_strobe & run_control_one;

  wire [16:0] step_zero = dtc_step(mode_field_zero, count_low_zero,
                                   count_high_zero);
  wire [16:0] step_one  = dtc_step(mode_field_one, count_low_one,
                                   count_high_one);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  reg        aw_full;
  reg        w_full;
  reg  [3:0] aw_index;
  reg  [7:0] w_byte;
  reg        w_lane;

  assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_full & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire wr_go  = aw_full & w_full & ~s_axi_bvalid;
  wire wr_hit = wr_go & w_lane & (aw_index <= `DTC_OFS_HIGH1);
  wire wr_ctrl  = wr_hit & (aw_index == `DTC_OFS_CTRL);
  wire wr_mode  = wr_hit & (aw_index == `DTC_OFS_MODE);
  wire wr_low0  = wr_hit & (aw_index == `DTC_OFS_LOW0);
  wire wr_high0 = wr_hit & (aw_index == `DTC_OFS_HIGH0);
  wire wr_low1  = wr_hit & (aw_index == `DTC_OFS_LOW1);
  wire wr_high1 = wr_hit & (aw_index == `DTC_OFS_HIGH1);

  wire [3:0] rd_index = s_axi_araddr[5:2];
  reg  [7:0] rd_byte;

  always @*
  begin
    case (rd_index)
      `DTC_OFS_CTRL:  rd_byte = timer_control_register;
      `DTC_OFS_MODE:  rd_byte = timer_mode_register;
      `DTC_OFS_LOW0:  rd_byte = count_low_zero;
      `DTC_OFS_HIGH0: rd_byte = count_high_zero;
      `DTC_OFS_LOW1:  rd_byte = count_low_one;
      `DTC_OFS_HIGH1: rd_byte = count_high_one;
      default:        rd_byte = 8'h00;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full      <= 1'b0;
      w_full       <= 1'b0;
      aw_index     <= 4'h0;
      w_byte       <= 8'h00;
      w_lane       <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DTC_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `DTC_RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full  <= 1'b1;
        aw_index <= s_axi_awaddr[5:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end
      if (wr_go)
      begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_index <= `DTC_OFS_HIGH1) ? `DTC_RESP_OKAY
                                                     : `DTC_RESP_DECERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= (rd_index <= `DTC_OFS_HIGH1) ? `DTC_RESP_OKAY
                                                     : `DTC_RESP_DECERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  reg [7:0] next_low_zero;
  reg [7:0] next_high_zero;
  reg [7:0] next_low_one;
  reg [7:0] next_high_one;
  reg       set_zero;
  reg       set_one;

  always @*
  begin
    next_low_zero  = count_low_zero;
    next_high_zero = count_high_zero;
    next_low_one   = count_low_one;
    next_high_one  = count_high_one;
    set_zero       = 1'b0;
    set_one        = 1'b0;
    if (split_mode)
    begin
      if (tick_zero)
      begin
        next_low_zero = count_low_zero + 8'h01;
        set_zero      = (count_low_zero == 8'hff);
      end
      if (tick_high)
      begin
        next_high_zero = count_high_zero + 8'h01;
        set_one        = (count_high_zero == 8'hff);
      end
    end
    else if (tick_zero)
    begin
      next_low_zero  = step_zero[7:0];
      next_high_zero = step_zero[15:8];
      set_zero       = step_zero[16];
    end
    // Mode 3 step holds the count
    if (tick_one)
    begin
      next_low_one  = step_one[7:0];
      next_high_one = step_one[15:8];
      if (!split_mode)
        set_one = step_one[16];
    end
    // Software presets take the place of a step
    if (wr_low0)
      next_low_zero = w_byte;
    if (wr_high0)
      next_high_zero = w_byte;
    if (wr_low1)
      next_low_one = w_byte;
    if (wr_high1)
      next_high_one = w_byte;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_control         <= `DTC_RST_CTRL;
      flag_zero           <= 1'b0;
      flag_one            <= 1'b0;
      timer_mode_register <= `DTC_RST_MODE;
      count_low_zero      <= `DTC_RST_COUNT;
      count_high_zero     <= `DTC_RST_COUNT;
      count_low_one       <= `DTC_RST_COUNT;
      count_high_one      <= `DTC_RST_COUNT;
    end
    else
    begin
      count_low_zero  <= next_low_zero;
      count_high_zero <= next_high_zero;
      count_low_one   <= next_low_one;
      count_high_one  <= next_high_one;
      if (wr_mode)
        timer_mode_register <= w_byte;
      if (wr_ctrl)
      begin
        run_control[`DTC_CTRL_RUN1] <= w_byte[`DTC_CTRL_RUN1];
        run_control[`DTC_CTRL_RUN0] <= w_byte[`DTC_CTRL_RUN0];
      end
      // Hardware set beats any clear
      if (set_zero)
        flag_zero <= 1'b1;
      else if (wr_ctrl)
        flag_zero <= w_byte[`DTC_CTRL_OVF0];
      else if (irq_ack_zero)
        flag_zero <= 1'b0;
      if (set_one)
        flag_one <= 1'b1;
      else if (wr_ctrl)
        flag_one <= w_byte[`DTC_CTRL_OVF1];
      else if (irq_ack_one)
        flag_one <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// [tb/dtc_checker_assertions.sv]
// Concurrent checks on the dual timer ports
`timescale 1ns/10ps
`default_nettype none
module dtc_checker
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Timer side
  input wire logic        periph_strobe,
  input wire logic        irq_ack_zero,
  input wire logic        irq_ack_one,
  input wire logic        overflow_flag_zero,
  input wire logic        overflow_flag_one
);
  default clocking dtc_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid lost");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid lost");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  aw_block_a: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write not held off");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read not held off");

  // ----------------------------------------------------------------
  // Overflow flags
  // ----------------------------------------------------------------
  flag0_set_a: assert property (
    $rose(overflow_flag_zero) |-> $past(periph_strobe) || $rose(s_axi_bvalid))
    else $error("flag zero set without cause");
  flag1_set_a: assert property (
    $rose(overflow_flag_one) |-> $past(periph_strobe) || $rose(s_axi_bvalid))
    else $error("flag one set without cause");
  flag0_clr_a: assert property (
    $fell(overflow_flag_zero) |-> $past(irq_ack_zero) || $rose(s_axi_bvalid))
    else $error("flag zero cleared without cause");
  flag1_clr_a: assert property (
    $fell(overflow_flag_one) |-> $past(irq_ack_one) || $rose(s_axi_bvalid))
    else $error("flag one cleared without cause");
endmodule

bind dtc_timer dtc_checker dtc_checker_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .periph_strobe, .irq_ack_zero, .irq_ack_one,
  .overflow_flag_zero, .overflow_flag_one
);
`default_nettype wire

// [tb/dtc_pins.sv]
// Far-side model: peripheral cycle strobe and external pins
`timescale 1ns/10ps
`default_nettype none
module dtc_pins
#(
  parameter int GAP = 5
)
(
  // Clock
  input  wire logic aclk,
  // Strobe and pins
  output var logic  periph_strobe,
  output var logic  count_pin_zero,
  output var logic  count_pin_one,
  output var logic  ext_gate_pin_zero,
  output var logic  ext_gate_pin_one
);
  initial
  begin
    periph_strobe = 1'b0;
    {ext_gate_pin_one, ext_gate_pin_zero, count_pin_one, count_pin_zero} = 4'h0;
  end

  // One peripheral cycle: pins held, strobe at its end
  task tick(input logic [3:0] p);
    begin
      {ext_gate_pin_one, ext_gate_pin_zero, count_pin_one, count_pin_zero} <= p;
      repeat (GAP) @(posedge aclk);
      periph_strobe <= 1'b1;
      @(posedge aclk);
      periph_strobe <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the dual timer
`timescale 1ns/10ps
`default_nettype none
`include "dtc_map.vh"
module tb;
  logic        aclk;
  logic        aresetn;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, irq_ack_zero, irq_ack_one;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, periph_strobe;
  logic        count_pin_zero, count_pin_one;
  logic        ext_gate_pin_zero, ext_gate_pin_one;
  logic        overflow_flag_zero, overflow_flag_one;
  int          n_errors, num_checks;

  dtc_timer dtc_timer_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .periph_strobe, .count_pin_zero, .count_pin_one, .ext_gate_pin_zero,
    .ext_gate_pin_one, .irq_ack_zero, .irq_ack_one, .overflow_flag_zero,
    .overflow_flag_one
  );
  dtc_pins dtc_pins_i (
    .aclk, .periph_strobe, .count_pin_zero, .count_pin_one,
    .ext_gate_pin_zero, .ext_gate_pin_one
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task close_out;
    begin
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
      num_checks++;
      if (seen !== exp)
      begin
        n_errors++;
        $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  task wr(input logic [3:0] i, input logic [7:0] d,
          input logic [1:0] er = `DTC_RESP_OKAY);
    logic       aw;
    logic       w;
    logic [1:0] r;
    begin
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (aw || w)
      begin
        @(negedge aclk);
        aw = aw && !s_axi_awready;
        w = w && !s_axi_wready;
        @(posedge aclk);
        s_axi_awvalid <= aw;
        s_axi_wvalid <= w;
      end
      do @(negedge aclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, r}, {30'h0, er});
      // Let an edge pass before the next call raises ready again
      @(posedge aclk);
    end
  endtask

  task rc(input string nm, input logic [3:0] i, input logic [31:0] e,
          input logic [1:0] er = `DTC_RESP_OKAY);
    logic [31:0] v;
    logic [1:0]  r;
    begin
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge aclk); while (!s_axi_arready);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (!s_axi_rvalid);
      v = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
      chk(nm, v, e);
      chk("rresp", {30'h0, r}, {30'h0, er});
      @(posedge aclk);
    end
  endtask

  task fl(input logic e0, input logic e1);
    begin
      @(negedge aclk);
      chk("flag0", {31'h0, overflow_flag_zero}, {31'h0, e0});
      chk("flag1", {31'h0, overflow_flag_one}, {31'h0, e1});
      @(posedge aclk);
    end
  endtask

  task ack(input logic one);
    begin
      irq_ack_zero <= !one;
      irq_ack_one <= one;
      @(posedge aclk);
      irq_ack_zero <= 1'b0;
      irq_ack_one <= 1'b0;
      @(posedge aclk);
    end
  endtask

  task tk(input int n, input logic [3:0] p);
    repeat (n) dtc_pins_i.tick(p);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    begin
      rc("ctrl", 4'h0, 32'h0);
      rc("mode", 4'h1, 32'h0);
      rc("hole", 4'h6, 32'h0, `DTC_RESP_DECERR);
      wr(4'h7, 8'h55, `DTC_RESP_DECERR);
    end
  endtask

  task t_wide;
    begin
      wr(4'h2, 8'hfe);
      wr(4'h3, 8'hff);
      wr(4'h1, 8'h01);
      wr(4'h0, 8'h10);
      tk(3, 4'h0);
      fl(1'b1, 1'b0);
      wr(4'h0, 8'h20);
      rc("low0", 4'h2, 32'h01);
      rc("high0", 4'h3, 32'h00);
      ack(1'b0);
      fl(1'b0, 1'b0);
      wr(4'h0, 8'h10);
      tk(1, 4'h0);
      wr(4'h0, 8'h00);
      rc("low0", 4'h2, 32'h02);
    end
  endtask

  task t_prescale;
    begin
      wr(4'h1, 8'h00);
      wr(4'h2, 8'h1e);
      wr(4'h3, 8'hff);
      wr(4'h0, 8'h10);
      tk(2, 4'h0);
      fl(1'b1, 1'b0);
      wr(4'h0, 8'h20);
      rc("low0", 4'h2, 32'h00);
      rc("high0", 4'h3, 32'h00);
      ack(1'b0);
    end
  endtask

  task t_reload;
    begin
      wr(4'h1, 8'h20);
      wr(4'h4, 8'hfe);
      wr(4'h5, 8'h40);
      wr(4'h0, 8'h40);
      tk(2, 4'h0);
      fl(1'b0, 1'b1);
      wr(4'h5, 8'h80);
      tk(1, 4'h0);
      wr(4'h0, 8'h80);
      rc("low1", 4'h4, 32'h41);
      rc("high1", 4'h5, 32'h80);
      ack(1'b1);
      fl(1'b0, 1'b0);
    end
  endtask

  task t_gate;
    begin
      wr(4'h0, 8'h00);
      wr(4'h1, 8'h0d);
      wr(4'h2, 8'h00);
      wr(4'h3, 8'h00);
      wr(4'h0, 8'h10);
      tk(1, 4'h1);
      tk(1, 4'h0);
      tk(1, 4'h5);
      tk(1, 4'h4);
      tk(2, 4'h5);
      wr(4'h0, 8'h00);
      rc("low0", 4'h2, 32'h01);
    end
  endtask

  task t_split;
    begin
      wr(4'h1, 8'h33);
      wr(4'h2, 8'hfe);
      wr(4'h3, 8'hfe);
      wr(4'h4, 8'h05);
      wr(4'h0, 8'h50);
      tk(2, 4'h0);
      fl(1'b1, 1'b1);
      wr(4'h0, 8'ha0);
      rc("low0", 4'h2, 32'h00);
      rc("high0", 4'h3, 32'h00);
      rc("low1", 4'h4, 32'h05);
      ack(1'b0);
      ack(1'b1);
      fl(1'b0, 1'b0);
    end
  endtask

  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  initial
  begin
    n_errors = 0;
    num_checks = 0;
    aresetn = 1'b0;
    s_axi_awaddr = 6'h00;
    s_axi_araddr = 6'h00;
    s_axi_wdata = 32'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    irq_ack_zero = 1'b0;
    irq_ack_one = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_wide();
    t_prescale();
    t_reload();
    t_gate();
    t_split();
    close_out();
  end

  initial
  begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    close_out();
  end
endmodule
`default_nettype wire
